/* pkg/fsp_pkg.sv */
// Constants, field layout and state encodings of the flash self-program controller.
// Assumes a 200 MHz core clock and a byte-addressed 32-bit register bus.
package fsp_pkg;

   // ==========================================================
   // Pointer and buffer geometry
   localparam int PTR_W = 22;
   localparam int LOW_W = 21;
   localparam int BLK_LSB = 10;
   localparam int HOLD_DEPTH = 64;
   localparam int HOLD_IDX_W = 6;
   localparam int DATA_W = 8;
   localparam int WORD_W = 16;
   localparam logic [HOLD_IDX_W-1:0] LAST_BLOCK_CNT = 6'h3F;
   localparam logic [HOLD_IDX_W-1:0] LAST_WORD_CNT = 6'h01;

   // ==========================================================
   // Register byte offsets
   localparam int ADDR_W = 5;
   localparam logic [ADDR_W-1:0] OFF_PTR_LOW = 5'h00;
   localparam logic [ADDR_W-1:0] OFF_PTR_HIGH = 5'h04;
   localparam logic [ADDR_W-1:0] OFF_PTR_UPPER = 5'h08;
   localparam logic [ADDR_W-1:0] OFF_LATCH = 5'h0C;
   localparam logic [ADDR_W-1:0] OFF_CTRL = 5'h10;
   localparam logic [ADDR_W-1:0] OFF_KEY = 5'h14;
   localparam logic [ADDR_W-1:0] OFF_TABLE_CMD = 5'h18;

   // ==========================================================
   // Field positions
   localparam int BIT_LAUNCH = 1;
   localparam int BIT_WRITE_EN = 2;
   localparam int BIT_ERR = 3;
   localparam int BIT_ERASE = 4;
   localparam int BIT_WORD_SEL = 5;
   localparam int CMD_RD_BIT = 0;
   localparam int CMD_MODE_LSB = 1;
   localparam int UPPER_W = PTR_W - 16;

   // ==========================================================
   // Key values and reset values
   localparam logic [7:0] KEY_FIRST = 8'h55;
   localparam logic [7:0] KEY_SECOND = 8'hAA;
   localparam logic [PTR_W-1:0] PTR_RESET = 22'h000000;
   localparam logic [7:0] LATCH_RESET = 8'h00;

   // ==========================================================
   // Timing: long write duration, rounded down to whole cycles
   localparam longint LONG_WRITE_TIME_NS = 1000000;
   localparam longint CLK_PERIOD_NS = 5;
   localparam int LONG_WRITE_CYCLES = int'(LONG_WRITE_TIME_NS / CLK_PERIOD_NS);

   // ==========================================================
   // Encodings
   typedef enum logic [1:0] {
      PM_KEEP = 2'b00,
      PM_POST_INC = 2'b01,
      PM_POST_DEC = 2'b10,
      PM_PRE_INC = 2'b11
   } fsp_ptr_mode_t;

   typedef enum logic [1:0] {
      UK_IDLE = 2'b00,
      UK_FIRST = 2'b01,
      UK_ARMED = 2'b10
   } fsp_unlock_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_RD_ISSUE = 3'b001,
      ST_RD_CAPT = 3'b010,
      ST_STREAM = 3'b011,
      ST_TIMED = 3'b100
   } fsp_state_t;

endpackage : fsp_pkg

/* pkg/fsp_hold_if.sv */
// Port group between the controller and its holding buffer.
// Assumes both ends run on the same core clock.
`timescale 1ns/100ps
interface fsp_hold_if #(
   parameter int IDX_W = 6,
   parameter int DW = 8
);
   logic wr_en;
   logic [IDX_W-1:0] wr_idx;
   logic [DW-1:0] wr_data;
   logic [IDX_W-1:0] rd_idx;
   logic [DW-1:0] rd_data;

   modport ctrl (output wr_en, output wr_idx, output wr_data, output rd_idx, input rd_data);
   modport store (input wr_en, input wr_idx, input wr_data, input rd_idx, output rd_data);
endinterface : fsp_hold_if

/* rtl/fsp_hold_buf.sv */
// Write holding buffer: short writes land here, long writes stream it out.
// Assumes the controller drives it on the same clock; read data is one cycle late.
`timescale 1ns/100ps
module fsp_hold_buf #(
   parameter int DEPTH = 64,
   parameter int DW = 8
) (
   input wire logic clk_sys,
   input wire logic clk_en,
   fsp_hold_if.store hold
);
   // ==========================================================
   // Storage
   // No reset: contents survive both resets and completed programs
   logic [DW-1:0] mem [DEPTH];
   logic [DW-1:0] rd_data_reg;

   always_ff @(posedge clk_sys) begin
      if (clk_en) begin
         if (hold.wr_en) begin
            mem[hold.wr_idx] <= hold.wr_data;
         end
         rd_data_reg <= mem[hold.rd_idx];
      end
   end

   assign hold.rd_data = rd_data_reg;

endmodule : fsp_hold_buf

/* rtl/fsp_prog_timer.sv */
// Self-timed programming timer for long writes and erases.
// Assumes start and abort come from logic on the same clock.
`timescale 1ns/100ps
module fsp_prog_timer #(
   parameter int unsigned CYCLES = 200000
) (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic clk_en,
   input wire logic start,
   input wire logic abort,
   output logic done
);
   localparam int CW = $clog2(CYCLES + 1);

   // ==========================================================
   // Down counter
   logic [CW-1:0] count_reg;

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         count_reg <= '0;
      end else if (clk_en) begin
         if (abort) begin
            count_reg <= '0;
         end else if (start) begin
            count_reg <= CW'(CYCLES);
         end else if (count_reg != '0) begin
            count_reg <= count_reg - 1'b1;
         end
      end
   end

   // Done in the last counted cycle, so the busy span is CYCLES cycles
   assign done = clk_en && !abort && (count_reg == CW'(1));

endmodule : fsp_prog_timer

/* rtl/fsp_ctrl.sv */
// Flash self-program controller: table pointer, table latch, holding
// buffer writes, row erase and self-timed long writes.
// Assumes an Avalon-MM master on clk_sys and a flash macro on the same
// clock that returns a 16-bit word one cycle after it samples fl_rd_en.
//
// Summary of operation
// - Pointer is upper, high, low bytes joined.
// - Bit 21 selects ID and configuration space.
// - Four pointer update modes per table access.
// - Auto steps touch only low 21 bits.
// - Table read fetches byte into table latch.
// - Table write stores latch into holding slot.
// - Pointer bits 21:6 pick programmed block.
// - Erase clears 1024-byte block, low bits ignored.
// - Address bit 0 picks word byte.
// - Only row erase from this path.
// - Core stalls until programming timer ends.
// - Program writes 64 bytes or one word.
// - Flash changes only on long write.
// - Holding buffer kept after programming.
// - Word select picks 2 or 64 bytes.
// - Launch flag set-only, hardware clears it.
// - Abort flag on reset or improper launch.
// - Unlock key register reads zero.
`timescale 1ns/100ps
module fsp_ctrl
   import fsp_pkg::*;
#(
   parameter int unsigned LONG_CYCLES = LONG_WRITE_CYCLES
) (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic clk_en,
   input wire logic sys_reset_req,
   input wire logic [ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic [WORD_W-1:0] fl_rdata,
   output logic [PTR_W-1:0] fl_addr,
   output logic fl_rd_en,
   output logic fl_wr_en,
   output logic [DATA_W-1:0] fl_wr_data,
   output logic fl_erase,
   output logic core_stall
);

   // ==========================================================
   // Helpers
   function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] off);
      return addr == off;
   endfunction : hit

   function automatic logic [PTR_W-1:0] ptr_step(input logic [PTR_W-1:0] p, input logic down);
      logic [LOW_W-1:0] low;
      low = down ? p[LOW_W-1:0] - 1'b1 : p[LOW_W-1:0] + 1'b1;
      return {p[PTR_W-1], low};
   endfunction : ptr_step

   // ==========================================================
   // State
   fsp_state_t state_reg;
   fsp_unlock_t unlock_reg;
   logic [PTR_W-1:0] ptr_reg;
   logic [DATA_W-1:0] latch_reg;
   logic word_program_select_reg;
   logic erase_sel_reg;
   logic err_reg;
   logic write_enable_bit_reg;
   logic launch_reg;
   logic wait_reg;
   logic [31:0] rdata_reg;
   logic [HOLD_IDX_W-1:0] cnt_reg;
   logic rd_v_reg;
   logic [HOLD_IDX_W-1:0] idx_d_reg;
   logic [PTR_W-1:0] fl_addr_reg;
   logic fl_rd_en_reg;
   logic fl_wr_en_reg;
   logic [DATA_W-1:0] fl_wr_data_reg;
   logic fl_erase_reg;
   logic stall_reg;

   logic accept;
   logic wr_acc;
   logic rd_acc;
   logic tbl_rd;
   logic tbl_wr;
   logic key_wr;
   logic ctl_wr;
   logic launch_req;
   logic launch_ok;
   logic launch_bad;
   logic launch_erase;
   logic timer_start;
   logic timer_done;
   logic ack;
   fsp_ptr_mode_t mode;
   logic [PTR_W-1:0] eff_ptr;
   logic [PTR_W-1:0] next_ptr;
   logic [HOLD_IDX_W-1:0] base_idx;
   logic [HOLD_IDX_W-1:0] last_cnt;

   fsp_hold_if #(.IDX_W(HOLD_IDX_W), .DW(DATA_W)) hold ();

   // ==========================================================
   // Bus decode
   // Requests are taken only while idle; a long write holds the bus
   assign accept = (avs_read || avs_write) && wait_reg && (state_reg == ST_IDLE)
                   && !sys_reset_req;
   assign wr_acc = accept && avs_write && avs_byteenable[0];
   assign rd_acc = accept && avs_read;
   assign mode = fsp_ptr_mode_t'(avs_writedata[CMD_MODE_LSB +: 2]);
   assign tbl_rd = wr_acc && hit(avs_address, OFF_TABLE_CMD) && avs_writedata[CMD_RD_BIT];
   assign tbl_wr = wr_acc && hit(avs_address, OFF_TABLE_CMD) && !avs_writedata[CMD_RD_BIT];
   assign key_wr = wr_acc && hit(avs_address, OFF_KEY);
   assign ctl_wr = wr_acc && hit(avs_address, OFF_CTRL);
   assign launch_req = ctl_wr && avs_writedata[BIT_LAUNCH];
   assign launch_ok = launch_req && (unlock_reg == UK_ARMED) && avs_writedata[BIT_WRITE_EN];
   assign launch_bad = launch_req && !launch_ok;
   assign launch_erase = launch_ok && avs_writedata[BIT_ERASE];

   // ==========================================================
   // Pointer arithmetic
   always_comb begin
      eff_ptr = ptr_reg;
      next_ptr = ptr_reg;
      unique case (mode)
         PM_KEEP: next_ptr = ptr_reg;
         PM_POST_INC: next_ptr = ptr_step(ptr_reg, 1'b0);
         PM_POST_DEC: next_ptr = ptr_step(ptr_reg, 1'b1);
         PM_PRE_INC: begin
            eff_ptr = ptr_step(ptr_reg, 1'b0);
            next_ptr = eff_ptr;
         end
      endcase
   end

   assign base_idx = word_program_select_reg ? {ptr_reg[HOLD_IDX_W-1:1], 1'b0} : '0;
   assign last_cnt = word_program_select_reg ? LAST_WORD_CNT : LAST_BLOCK_CNT;
   assign timer_start = launch_erase
                        || ((state_reg == ST_STREAM) && (cnt_reg == last_cnt) && !sys_reset_req);

   // ==========================================================
   // Bus answer
   always_comb begin
      ack = 1'b0;
      if (sys_reset_req) begin
         ack = state_reg != ST_IDLE;
      end else if (state_reg == ST_IDLE) begin
         ack = accept && !tbl_rd && !launch_ok;
      end else if (state_reg == ST_RD_CAPT) begin
         ack = 1'b1;
      end else if (state_reg == ST_TIMED) begin
         ack = timer_done;
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         wait_reg <= 1'b1;
      end else if (clk_en) begin
         wait_reg <= !ack;
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         rdata_reg <= 32'h00000000;
      end else if (clk_en && rd_acc) begin
         rdata_reg <= 32'h00000000;
         if (hit(avs_address, OFF_PTR_LOW)) begin
            rdata_reg[7:0] <= ptr_reg[7:0];
         end else if (hit(avs_address, OFF_PTR_HIGH)) begin
            rdata_reg[7:0] <= ptr_reg[15:8];
         end else if (hit(avs_address, OFF_PTR_UPPER)) begin
            rdata_reg[UPPER_W-1:0] <= ptr_reg[PTR_W-1:16];
         end else if (hit(avs_address, OFF_LATCH)) begin
            rdata_reg[7:0] <= latch_reg;
         end else if (hit(avs_address, OFF_CTRL)) begin
            rdata_reg[BIT_WORD_SEL] <= word_program_select_reg;
            rdata_reg[BIT_ERASE] <= erase_sel_reg;
            rdata_reg[BIT_ERR] <= err_reg;
            rdata_reg[BIT_WRITE_EN] <= write_enable_bit_reg;
            rdata_reg[BIT_LAUNCH] <= launch_reg;
         end
      end
   end

   // ==========================================================
   // Sequencer
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         state_reg <= ST_IDLE;
      end else if (clk_en) begin
         if (sys_reset_req) begin
            state_reg <= ST_IDLE;
         end else begin
            unique case (state_reg)
               ST_IDLE: begin
                  if (tbl_rd) begin
                     state_reg <= ST_RD_ISSUE;
                  end else if (launch_erase) begin
                     state_reg <= ST_TIMED;
                  end else if (launch_ok) begin
                     state_reg <= ST_STREAM;
                  end
               end
               ST_RD_ISSUE: state_reg <= ST_RD_CAPT;
               ST_RD_CAPT: state_reg <= ST_IDLE;
               ST_STREAM: begin
                  if (timer_start) begin
                     state_reg <= ST_TIMED;
                  end
               end
               ST_TIMED: begin
                  if (timer_done) begin
                     state_reg <= ST_IDLE;
                  end
               end
               default: state_reg <= ST_IDLE;
            endcase
         end
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         cnt_reg <= '0;
      end else if (clk_en) begin
         cnt_reg <= (state_reg == ST_STREAM) ? cnt_reg + 1'b1 : '0;
      end
   end

   // ==========================================================
   // Table pointer and latch
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         ptr_reg <= PTR_RESET;
      end else if (clk_en) begin
         if (wr_acc && hit(avs_address, OFF_PTR_LOW)) begin
            ptr_reg[7:0] <= avs_writedata[7:0];
         end else if (wr_acc && hit(avs_address, OFF_PTR_HIGH)) begin
            ptr_reg[15:8] <= avs_writedata[7:0];
         end else if (wr_acc && hit(avs_address, OFF_PTR_UPPER)) begin
            ptr_reg[PTR_W-1:16] <= avs_writedata[UPPER_W-1:0];
         end else if (tbl_rd || tbl_wr) begin
            ptr_reg <= next_ptr;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         latch_reg <= LATCH_RESET;
      end else if (clk_en) begin
         if (wr_acc && hit(avs_address, OFF_LATCH)) begin
            latch_reg <= avs_writedata[7:0];
         end else if (state_reg == ST_RD_CAPT && !sys_reset_req) begin
            latch_reg <= fl_addr_reg[0] ? fl_rdata[15:8] : fl_rdata[7:0];
         end
      end
   end

   // ==========================================================
   // Control bits and unlock
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         word_program_select_reg <= 1'b0;
         erase_sel_reg <= 1'b0;
         write_enable_bit_reg <= 1'b0;
      end else if (clk_en) begin
         if (sys_reset_req) begin
            write_enable_bit_reg <= 1'b0;
            erase_sel_reg <= 1'b0;
         end else if (ctl_wr) begin
            word_program_select_reg <= avs_writedata[BIT_WORD_SEL];
            erase_sel_reg <= avs_writedata[BIT_ERASE];
            write_enable_bit_reg <= avs_writedata[BIT_WRITE_EN];
         end else if (state_reg == ST_TIMED && timer_done) begin
            erase_sel_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         launch_reg <= 1'b0;
      end else if (clk_en) begin
         if (sys_reset_req || timer_done) begin
            launch_reg <= 1'b0;
         end else if (launch_ok) begin
            launch_reg <= 1'b1;
         end
      end
   end

   // Error flag is high while an operation runs, so an abort leaves it set
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         err_reg <= 1'b0;
      end else if (clk_en) begin
         if (launch_ok || launch_bad) begin
            err_reg <= 1'b1;
         end else if (timer_done && !sys_reset_req) begin
            err_reg <= 1'b0;
         end else if (ctl_wr) begin
            err_reg <= avs_writedata[BIT_ERR];
         end
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         unlock_reg <= UK_IDLE;
      end else if (clk_en) begin
         if (sys_reset_req) begin
            unlock_reg <= UK_IDLE;
         end else if (accept && avs_write) begin
            if (key_wr && avs_writedata[7:0] == KEY_FIRST) begin
               unlock_reg <= UK_FIRST;
            end else if (key_wr && avs_writedata[7:0] == KEY_SECOND
                         && unlock_reg == UK_FIRST) begin
               unlock_reg <= UK_ARMED;
            end else begin
               unlock_reg <= UK_IDLE;
            end
         end
      end
   end

   // ==========================================================
   // Holding buffer and timer
   // latch into slot
   assign hold.wr_en = tbl_wr;
   assign hold.wr_idx = eff_ptr[HOLD_IDX_W-1:0];
   assign hold.wr_data = latch_reg;
   assign hold.rd_idx = base_idx + cnt_reg;

   fsp_hold_buf #(.DEPTH(HOLD_DEPTH), .DW(DATA_W)) u_hold (
      .clk_sys(clk_sys),
      .clk_en(clk_en),
      .hold(hold.store)
   );

   fsp_prog_timer #(.CYCLES(LONG_CYCLES)) u_timer (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .clk_en(clk_en),
      .start(timer_start),
      .abort(sys_reset_req),
      .done(timer_done)
   );

   // ==========================================================
   // Flash macro side
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         rd_v_reg <= 1'b0;
         idx_d_reg <= '0;
         fl_wr_en_reg <= 1'b0;
         fl_wr_data_reg <= 8'h00;
      end else if (clk_en) begin
         rd_v_reg <= (state_reg == ST_STREAM) && !sys_reset_req;
         idx_d_reg <= hold.rd_idx;
         fl_wr_en_reg <= rd_v_reg && !sys_reset_req;
         fl_wr_data_reg <= hold.rd_data;
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         fl_addr_reg <= PTR_RESET;
         fl_rd_en_reg <= 1'b0;
         fl_erase_reg <= 1'b0;
      end else if (clk_en) begin
         fl_rd_en_reg <= tbl_rd;
         fl_erase_reg <= launch_erase;
         if (tbl_rd) begin
            fl_addr_reg <= eff_ptr;
         end else if (launch_erase) begin
            fl_addr_reg <= {ptr_reg[PTR_W-1:BLK_LSB], {BLK_LSB{1'b0}}};
         end else if (rd_v_reg) begin
            fl_addr_reg <= {ptr_reg[PTR_W-1:HOLD_IDX_W], idx_d_reg};
         end
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         stall_reg <= 1'b0;
      end else if (clk_en) begin
         if (sys_reset_req || timer_done) begin
            stall_reg <= 1'b0;
         end else if (launch_ok) begin
            stall_reg <= 1'b1;
         end
      end
   end

   assign avs_readdata = rdata_reg;
   assign avs_waitrequest = wait_reg;
   assign fl_addr = fl_addr_reg;
   assign fl_rd_en = fl_rd_en_reg;
   assign fl_wr_en = fl_wr_en_reg;
   assign fl_wr_data = fl_wr_data_reg;
   assign fl_erase = fl_erase_reg;
   assign core_stall = stall_reg;

endmodule : fsp_ctrl

/* dv/fsp_flash_model.sv */
// Flash macro model: one 16-bit word a read.
// Assumes reads are sampled on clk_sys.
`timescale 1ns/100ps
module fsp_flash_model
   import fsp_pkg::*;
(
   input wire logic clk_sys,
   input wire logic fl_rd_en,
   input wire logic [PTR_W-1:0] fl_addr,
   output logic [WORD_W-1:0] fl_rdata = 16'h0000
);
   // ==========================================================
   // word from address
   // Off read the bus flips, so stale data never matches
   always_ff @(posedge clk_sys) begin
      if (fl_rd_en) begin
         fl_rdata <= {{fl_addr[21], fl_addr[7:1]} ^ 8'hA5, fl_addr[21], fl_addr[7:1]};
      end else begin
         fl_rdata <= ~fl_rdata;
      end
   end
endmodule : fsp_flash_model

/* dv/fsp_ctrl_monitor.sv */
// Checker on the controller's top ports.
// Assumes one clock domain and reset_n active low.
`timescale 1ns/100ps
module fsp_ctrl_monitor
   import fsp_pkg::*;
(
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic clk_en,
   input wire logic sys_reset_req,
   input wire logic [ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic [PTR_W-1:0] fl_addr,
   input wire logic fl_rd_en,
   input wire logic fl_wr_en,
   input wire logic fl_erase,
   input wire logic core_stall
);
   // ==========================================================
   // Properties
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!reset_n);
   sequence rd_cmd;
      $rose(avs_write) && avs_address == OFF_TABLE_CMD && avs_writedata[0] && clk_en
         && !sys_reset_req;
   endsequence
   sequence rd_walk;
      fl_rd_en ##1 !fl_rd_en ##1 !avs_waitrequest;
   endsequence
   sequence key_rd;
      avs_read && avs_address == OFF_KEY && avs_waitrequest ##1 !avs_waitrequest;
   endsequence
   a_table_rd_walk: assert property (rd_cmd |=> rd_walk)
      else $error("table read walk broken");
   a_key_reads_zero: assert property (key_rd |-> avs_readdata == 32'h0)
      else $error("unlock key read not zero");
   a_erase_block_align: assert property (fl_erase |-> fl_addr[9:0] == 10'h0)
      else $error("erase address not block aligned");
   a_erase_one_pulse: assert property (fl_erase |=> !fl_erase [*8])
      else $error("erase repeated");
   a_stall_no_read: assert property (core_stall |-> !fl_rd_en)
      else $error("flash read while stalled");
   a_cells_need_stall: assert property (fl_wr_en || fl_erase |-> core_stall)
      else $error("flash cells changed outside long write");
   a_stall_from_ctrl: assert property ($rose(core_stall) |->
      $past(avs_write) && $past(avs_address) == OFF_CTRL)
      else $error("stall without control write");
   a_prog_block_kept: assert property (fl_wr_en ##1 fl_wr_en |->
      $stable(fl_addr[21:6]))
      else $error("program block moved");
endmodule : fsp_ctrl_monitor

bind fsp_ctrl fsp_ctrl_monitor u_mon (.clk_sys, .reset_n, .clk_en, .sys_reset_req,
   .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
   .avs_waitrequest, .fl_addr, .fl_rd_en, .fl_wr_en, .fl_erase, .core_stall);

/* dv/fsp_ctrl_tb_top.sv */
// Bench: register bus master, flash model, write watcher.
// Assumes LONG_CYCLES is shortened to 20.
`timescale 1ns/100ps
module fsp_ctrl_tb_top
   import fsp_pkg::*;
;
   typedef struct packed {
      logic [1:0] mode;
      logic [21:0] ptr;
      logic [21:0] addr;
      logic [21:0] next;
   } fsp_row_t;
   // Mid value for keep, then boundaries of the low 21 bits, both values of bit 21
   fsp_row_t rows [4] = '{
      '{PM_KEEP, 22'h000123, 22'h000123, 22'h000123},
      '{PM_POST_INC, 22'h1FFFFF, 22'h1FFFFF, 22'h000000},
      '{PM_POST_DEC, 22'h200000, 22'h200000, 22'h3FFFFF},
      '{PM_PRE_INC, 22'h3FFFFF, 22'h200000, 22'h200000}};
   logic clk_sys = 1'h0;
   logic reset_n = 1'h0;
   logic sys_reset_req = 1'h0;
   logic [ADDR_W-1:0] avs_address = '0;
   logic avs_read = 1'h0;
   logic avs_write = 1'h0;
   logic [31:0] avs_writedata = '0;
   logic [3:0] avs_byteenable = 4'hF;
   logic [31:0] avs_readdata, q;
   logic avs_waitrequest, fl_rd_en, fl_wr_en, fl_erase, core_stall;
   logic [WORD_W-1:0] fl_rdata;
   logic [PTR_W-1:0] fl_addr, ebase;
   logic [DATA_W-1:0] fl_wr_data;
   logic [15:0] hi;
   int errors = 0;
   int comparisons = 0;
   int cycles = 0;
   int wcnt = 0;
   int ecnt = 0;

   always #2.5 clk_sys = ~clk_sys;
   fsp_ctrl #(.LONG_CYCLES(20)) dut (.clk_sys, .reset_n, .clk_en(1'h1), .sys_reset_req,
      .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
      .avs_waitrequest, .fl_rdata, .fl_addr, .fl_rd_en, .fl_wr_en, .fl_wr_data, .fl_erase,
      .core_stall);
   fsp_flash_model u_flash (.clk_sys, .fl_rd_en, .fl_addr, .fl_rdata);

   // ==========================================================
   // Tasks
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      comparisons++;
      if (s !== e) begin
         errors++;
         $display("ERROR %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic end_of_test();
      if (errors == 0 && comparisons > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : end_of_test
   task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      avs_address <= a;
      avs_writedata <= {24'h000000, d};
      avs_write <= w;
      avs_read <= ~w;
      do @(posedge clk_sys); while (avs_waitrequest !== 1'h0);
      q = avs_readdata;
      avs_write <= 1'h0;
      avs_read <= 1'h0;
   endtask : bus
   task automatic set_ptr(input logic [21:0] p);
      bus(1'h1, OFF_PTR_LOW, p[7:0]);
      bus(1'h1, OFF_PTR_HIGH, p[15:8]);
      bus(1'h1, OFF_PTR_UPPER, {2'h0, p[21:16]});
   endtask : set_ptr
   task automatic chk_ptr(input logic [21:0] p);
      bus(1'h0, OFF_PTR_LOW, 8'h00);
      chk("ptr low", p[7:0], q);
      bus(1'h0, OFF_PTR_HIGH, 8'h00);
      chk("ptr high", p[15:8], q);
      bus(1'h0, OFF_PTR_UPPER, 8'h00);
      chk("ptr upper", p[21:16], q);
   endtask : chk_ptr
   task automatic launch(input logic [7:0] c);
      bus(1'h1, OFF_KEY, KEY_FIRST);
      bus(1'h1, OFF_KEY, KEY_SECOND);
      bus(1'h1, OFF_CTRL, c);
   endtask : launch
   task automatic rst();
      reset_n <= 1'h0;
      repeat (10) @(posedge clk_sys);
      reset_n <= 1'h1;
   endtask : rst
   function automatic logic [7:0] exp_byte(input logic [21:0] a);
      return a[0] ? {a[21], a[7:1]} ^ 8'hA5 : {a[21], a[7:1]};
   endfunction : exp_byte

   // ==========================================================
   // Watchers
   always @(posedge clk_sys) begin
      if (fl_wr_en === 1'h1) begin
         chk("prog addr", {hi, 6'(wcnt)}, fl_addr);
         chk("prog data", 8'(wcnt) ^ 8'h3C, fl_wr_data);
         wcnt++;
      end
      if (fl_erase === 1'h1) begin
         chk("erase addr", ebase, fl_addr);
         ecnt++;
      end
      cycles++;
      if (cycles == 20000) begin
         errors++;
         end_of_test();
      end
   end

   // ==========================================================
   // Sequence
   initial begin
      rst();
      chk_ptr(22'h000000);
      bus(1'h0, OFF_CTRL, 8'h00);
      chk("ctrl reset", 32'h0, q);
      foreach (rows[i]) begin
         set_ptr(rows[i].ptr);
         bus(1'h1, OFF_TABLE_CMD, {5'h00, rows[i].mode, 1'h1});
         bus(1'h0, OFF_LATCH, 8'h00);
         chk("latch", exp_byte(rows[i].addr), q);
         chk_ptr(rows[i].next);
      end
      avs_byteenable <= 4'h0;
      bus(1'h1, OFF_PTR_LOW, 8'h5A);
      avs_byteenable <= 4'hF;
      bus(1'h0, OFF_PTR_LOW, 8'h00);
      chk("masked write", 32'h0, q);
      bus(1'h0, 5'h1C, 8'h00);
      chk("unmapped", 32'h0, q);
      bus(1'h1, OFF_KEY, KEY_FIRST);
      bus(1'h0, OFF_KEY, 8'h00);
      chk("key read", 32'h0, q);
      bus(1'h1, OFF_KEY, KEY_SECOND);
      bus(1'h1, OFF_LATCH, 8'h00);
      bus(1'h1, OFF_CTRL, 8'h06);
      launch(8'h02);
      chk("refused ops", 0, wcnt + ecnt);
      bus(1'h0, OFF_CTRL, 8'h00);
      chk("err flag", 32'h8, q & 32'h8);
      set_ptr(22'h000440);
      for (int i = 0; i < 64; i++) begin
         bus(1'h1, OFF_LATCH, 8'(i) ^ 8'h3C);
         bus(1'h1, OFF_TABLE_CMD, {5'h00, PM_POST_INC, 1'h0});
      end
      chk("no short prog", 0, wcnt);
      hi = 16'h0012;
      launch(8'h06);
      chk("block bytes", 64, wcnt);
      bus(1'h0, OFF_CTRL, 8'h00);
      chk("launch clear", 32'h0, q & 32'hA);
      set_ptr(22'h0004C0);
      hi = 16'h0013;
      wcnt = 0;
      launch(8'h26);
      chk("word bytes", 2, wcnt);
      set_ptr(22'h0007FF);
      ebase = 22'h000400;
      launch(8'h16);
      chk("erase count", 1, ecnt);
      chk("stall end", 0, core_stall);
      fork
         launch(8'h16);
         begin
            repeat (14) @(posedge clk_sys);
            chk("stall", 1, core_stall);
            sys_reset_req <= 1'h1;
            @(posedge clk_sys);
            sys_reset_req <= 1'h0;
         end
      join
      bus(1'h0, OFF_CTRL, 8'h00);
      chk("abort flag", 32'h8, q & 32'hA);
      rst();
      chk_ptr(22'h000000);
      end_of_test();
   end
endmodule : fsp_ctrl_tb_top
